// File: mpt_pkg.sv
// Operation
// R1 - Latch first half-word, then drop half-select
// R2 - Decode window pulses low 350 ns later
// R3 - Commands asserted only inside decode window
// R4 - Three-bit field picks one of eight; zero idle
// R5 - Hold first half until second half decoded
// R6 - Two-stage next-state pipeline feeds store address
// R7 - All timing derived from 4 MHz master tick; the decode window counts 10 MHz clock cycles instead
// R8 - Process cycle spans two sequence-advance pulses
// R9 - Single, fifteen or sixteen shift pulses per cycle
// R10 - Four-bit counter, carry low then high after 16
// R11 - Carry high blocks shifts, raises half-select
// R12 - Slot after last shift strobes latch, ends cycle
// R13 - Fifteen mode preloads counter to one
// R14 - Single mode passes exactly one shift pulse
// R15 - Scaler reads halve shift rate first 13 places
// R16 - Halving ends at counter code twelve
// R17 - Rate switches only on master tick
// R18 - Store address is half-select plus seven state bits
// R19 - Reset: half-select low, counter clear, commands idle
package mpt_pkg;
    localparam int CLK_HZ = 10_000_000;
    localparam int MOSC_HZ = 4_000_000;
    localparam int DEC_DLY_NS = 350;
    localparam int DEC_WIN_NS = 250;
    localparam int CLK_NS = 1_000_000_000 / CLK_HZ;
    localparam int DEC_DLY_CYC = (DEC_DLY_NS + CLK_NS - 1) / CLK_NS;
    localparam int DEC_WIN_CYC = (DEC_WIN_NS / CLK_NS < 1) ? 1 : DEC_WIN_NS / CLK_NS;
    localparam int CNT_W = 4;
    localparam int STATE_W = 7;
    localparam int FIELD_W = 3;
    localparam int N_FIELDS = 2;
    localparam int CODE_W = 16;
    localparam int BIT_SINGLE_N = 6;
    localparam int BIT_FIFTEEN = 7;
    localparam logic [3:0] CNT_FIFTEEN_LOAD = 4'h1;
    localparam logic [3:0] CNT_REST = 4'hf;
    localparam logic [1:0] CNT_HALVE_END = 2'h3;
    localparam logic [1:0] DIV_NORMAL = 2'h1;
    localparam logic [1:0] DIV_HALVED = 2'h3;
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_CYCLES = 12'h008;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADV,
        ST_STB_WAIT,
        ST_STB,
        ST_SHIFT
    } mpt_state_e;
endpackage : mpt_pkg

// File: mpt_timing.sv
`timescale 1ns/10ps
module mpt_timing #(
    parameter int CODE_W = mpt_pkg::CODE_W,
    parameter int N_FIELDS = mpt_pkg::N_FIELDS
) (
    input wire logic CLOCK,
    input wire logic SYS_RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic [CODE_W-1:0] MCODE,
    input wire logic [mpt_pkg::STATE_W-1:0] NEXT_STATE_LINES,
    input wire logic SCALER_RD,
    output logic [mpt_pkg::STATE_W:0] STORE_ADDR,
    output logic HALF_SEL,
    output logic SEQ_ADV_CLK_N,
    output logic COMMAND_LATCH_STROBE,
    output logic DECODE_WINDOW_PULSE_N,
    output logic SHIFT_CLK,
    output logic PLUGIN_SIDE_CLOCK,
    output logic MASTER_OSC_CLOCK,
    output logic COUNTER_CARRY,
    output logic [CODE_W-1:0] FIRST_CODES,
    output logic [N_FIELDS*8-1:0] DEC_CMD
);
    localparam int SW = mpt_pkg::STATE_W;
    localparam int FW = mpt_pkg::FIELD_W;

    function automatic logic [7:0] dec8(input logic [FW-1:0] f);
        logic [7:0] o;
        o = 8'h00;
        o[f] = 1'b1;
        o[0] = 1'b0; // see R4
        return o;
    endfunction : dec8

    // Fractional accumulator: 4 MHz average tick from the 10 MHz clock
    logic [23:0] acc_ff;
    logic mtick;
    logic [23:0] acc_sum;
    assign acc_sum = acc_ff + 24'(mpt_pkg::MOSC_HZ / 1000);
    assign mtick = acc_sum >= 24'(mpt_pkg::CLK_HZ / 1000);
    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            acc_ff <= 24'h00_0000;
        end else if (mtick) begin // see R7
            acc_ff <= acc_sum - 24'(mpt_pkg::CLK_HZ / 1000);
        end else begin
            acc_ff <= acc_sum;
        end
    end

    logic mosc_ff;
    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            mosc_ff <= 1'b0;
        end else if (mtick) begin
            mosc_ff <= ~mosc_ff;
        end
    end
    assign MASTER_OSC_CLOCK = mosc_ff;

    // Slot divider; limit changes only on a master tick
    logic [1:0] div_ff;
    logic halve_ff;
    logic slot;
    logic [1:0] div_lim;
    assign div_lim = halve_ff ? mpt_pkg::DIV_HALVED : mpt_pkg::DIV_NORMAL;
    assign slot = mtick && (div_ff >= div_lim);
    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            div_ff <= 2'h0;
        end else if (mtick) begin // see R17
            div_ff <= slot ? 2'h0 : div_ff + 2'h1;
        end
    end

    logic pis_ff;
    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            pis_ff <= 1'b0;
        end else if (slot) begin
            pis_ff <= ~pis_ff;
        end
    end
    assign PLUGIN_SIDE_CLOCK = pis_ff;

    // Register file
    logic run_ff;
    logic [31:0] cycles_ff;
    logic [31:0] rdata;
    logic mapped;
    mpt_pkg::mpt_state_e state_ff;
    logic [mpt_pkg::CNT_W-1:0] cnt_ff;
    logic pulsed_ff;
    always_comb begin
        mapped = 1'b1;
        rdata = 32'h0000_0000;
        case (PADDR)
            mpt_pkg::ADDR_CTRL: rdata = {31'h0000_0000, run_ff};
            mpt_pkg::ADDR_STATUS: rdata = {20'h0_0000, halve_ff, COUNTER_CARRY,
                HALF_SEL, SEQ_ADV_CLK_N, cnt_ff, 1'b0, state_ff};
            mpt_pkg::ADDR_CYCLES: rdata = cycles_ff;
            default: mapped = 1'b0;
        endcase
    end
    assign PREADY = 1'b1;
    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            PRDATA <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end else if (PSEL && !PENABLE) begin
            PRDATA <= PWRITE ? 32'h0000_0000 : rdata;
            PSLVERR <= ~mapped;
        end
    end
    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            run_ff <= mpt_pkg::CTRL_RESET[0];
        end else if (PSEL && PENABLE && PWRITE && PADDR == mpt_pkg::ADDR_CTRL) begin
            run_ff <= PWDATA[0];
        end
    end

    // Process-cycle sequencer
    logic single_n;
    logic fifteen;
    logic [mpt_pkg::CNT_W-1:0] cnt_nxt;
    logic last_shift;
    assign single_n = MCODE[mpt_pkg::BIT_SINGLE_N];
    assign fifteen = MCODE[mpt_pkg::BIT_FIFTEEN];
    // Fifteen mode preloads one so wrap comes a pulse early
    assign cnt_nxt = (!pulsed_ff && fifteen) ? mpt_pkg::CNT_FIFTEEN_LOAD
        : cnt_ff + 4'h1; // see R13
    assign last_shift = !single_n || (cnt_nxt == mpt_pkg::CNT_REST); // see R9

    logic half_ff;
    logic adv_n_ff;
    logic stb_ff;
    logic shift_ff;
    logic carry_ff;
    logic start_dec_ff;
    logic dly_ff;
    logic win_n_ff;
    logic dec_busy;
    // Closing pulse waits for the window, else single mode loses its commands
    assign dec_busy = start_dec_ff || dly_ff || !win_n_ff;
    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            state_ff <= mpt_pkg::ST_IDLE;
            half_ff <= 1'b0; // see R19
            adv_n_ff <= 1'b1;
            stb_ff <= 1'b0;
            shift_ff <= 1'b0;
            carry_ff <= 1'b1;
            cnt_ff <= 4'h0;
            pulsed_ff <= 1'b0;
            start_dec_ff <= 1'b0;
            cycles_ff <= 32'h0000_0000;
        end else begin
            shift_ff <= 1'b0;
            start_dec_ff <= 1'b0;
            case (state_ff)
                mpt_pkg::ST_IDLE: begin
                    if (slot && run_ff) begin
                        half_ff <= 1'b1;
                        state_ff <= mpt_pkg::ST_ADV;
                    end
                end
                mpt_pkg::ST_ADV: begin
                    if (mtick) begin // see R11
                        adv_n_ff <= 1'b0;
                        state_ff <= mpt_pkg::ST_STB_WAIT;
                    end
                end
                mpt_pkg::ST_STB_WAIT: begin
                    // Slot after the last shift strobes instead of shifting
                    if (slot) begin // see R12
                        stb_ff <= 1'b1;
                        state_ff <= mpt_pkg::ST_STB;
                    end
                end
                mpt_pkg::ST_STB: begin
                    if (mtick) begin // see R1 R8
                        stb_ff <= 1'b0;
                        half_ff <= 1'b0;
                        adv_n_ff <= 1'b1;
                        start_dec_ff <= 1'b1;
                        cycles_ff <= cycles_ff + 32'h0000_0001;
                        // Rest at all ones: carry high, first count wraps to zero, or loads one in fifteen mode
                        cnt_ff <= mpt_pkg::CNT_REST;
                        pulsed_ff <= 1'b0;
                        state_ff <= run_ff ? mpt_pkg::ST_SHIFT : mpt_pkg::ST_IDLE;
                    end
                end
                mpt_pkg::ST_SHIFT: begin
                    if (slot && !(last_shift && dec_busy)) begin // see R8
                        shift_ff <= 1'b1; // see R10 R14
                        pulsed_ff <= 1'b1;
                        if (single_n) begin
                            cnt_ff <= cnt_nxt;
                            carry_ff <= (cnt_nxt == mpt_pkg::CNT_REST); // see R10
                        end
                        if (last_shift) begin
                            half_ff <= 1'b1; // see R11 R14
                            state_ff <= mpt_pkg::ST_ADV;
                        end
                    end
                end
                default: state_ff <= mpt_pkg::ST_IDLE;
            endcase
        end
    end
    assign HALF_SEL = half_ff;
    assign SEQ_ADV_CLK_N = adv_n_ff;
    assign COMMAND_LATCH_STROBE = stb_ff;
    assign SHIFT_CLK = shift_ff;
    assign COUNTER_CARRY = carry_ff;

    // Halved rate for scaler strobing; decided on master ticks only
    // Upper bits both high at code twelve, thirteen counts from rest
    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            halve_ff <= 1'b0;
        end else if (mtick) begin // see R15 R17
            halve_ff <= SCALER_RD && state_ff == mpt_pkg::ST_SHIFT && pulsed_ff
                && single_n && cnt_ff[3:2] != mpt_pkg::CNT_HALVE_END; // see R16
        end
    end

    // Two-stage next-state address pipeline
    logic [SW-1:0] stage1_ff;
    logic [SW-1:0] stage2_ff;
    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            stage1_ff <= '0;
            stage2_ff <= '0;
        end else begin
            if (state_ff == mpt_pkg::ST_STB_WAIT && slot && half_ff) begin
                stage1_ff <= NEXT_STATE_LINES; // see R6
            end
            if (state_ff == mpt_pkg::ST_STB && mtick) begin
                stage2_ff <= stage1_ff; // see R6
            end
        end
    end
    assign STORE_ADDR = {half_ff, stage2_ff}; // see R18

    // First half-word held until second half is decoded
    logic [CODE_W-1:0] first_ff;
    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            first_ff <= '0;
        end else if (state_ff == mpt_pkg::ST_STB && mtick) begin
            first_ff <= MCODE; // see R1 R5
        end
    end
    assign FIRST_CODES = first_ff;

    // Decode window after the half-select fall
    logic [7:0] wcnt_ff;
    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            wcnt_ff <= 8'h00;
            win_n_ff <= 1'b1;
            dly_ff <= 1'b0;
        end else if (start_dec_ff) begin
            wcnt_ff <= 8'(mpt_pkg::DEC_DLY_CYC - 2);
            dly_ff <= 1'b1;
            win_n_ff <= 1'b1;
        end else if (wcnt_ff != 8'h00) begin
            wcnt_ff <= wcnt_ff - 8'h01;
        end else if (dly_ff) begin // see R2
            dly_ff <= 1'b0;
            win_n_ff <= 1'b0;
            wcnt_ff <= 8'(mpt_pkg::DEC_WIN_CYC - 1);
        end else begin
            win_n_ff <= 1'b1;
        end
    end
    assign DECODE_WINDOW_PULSE_N = win_n_ff;

    // Outside the window every field is forced idle
    genvar gi;
    generate
        for (gi = 0; gi < N_FIELDS; gi++) begin : g_dec
            always_ff @(posedge CLOCK or posedge SYS_RST) begin
                if (SYS_RST) begin
                    DEC_CMD[gi*8 +: 8] <= 8'h00;
                end else begin
                    DEC_CMD[gi*8 +: 8] <= (!win_n_ff && !half_ff)
                        ? dec8(MCODE[gi*FW +: FW]) : 8'h00; // see R3 R4
                end
            end
        end
    endgenerate
endmodule : mpt_timing

// File: mpt_timing_sva.sv
`timescale 1ns/10ps
module mpt_chk #(
    parameter int CODE_W = mpt_pkg::CODE_W,
    parameter int N_FIELDS = mpt_pkg::N_FIELDS
) (
    input wire logic CLOCK,
    input wire logic SYS_RST,
    input wire logic HALF_SEL,
    input wire logic SEQ_ADV_CLK_N,
    input wire logic COMMAND_LATCH_STROBE,
    input wire logic DECODE_WINDOW_PULSE_N,
    input wire logic SHIFT_CLK,
    input wire logic COUNTER_CARRY,
    input wire logic [mpt_pkg::STATE_W:0] STORE_ADDR,
    input wire logic [CODE_W-1:0] FIRST_CODES,
    input wire logic [N_FIELDS*8-1:0] DEC_CMD
);
    logic [4:0] n_shift_ff;
    logic armed_ff;
    // Skip the first rise after reset: no shift phase precedes it
    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            armed_ff <= 1'b0;
        end else if ($fell(HALF_SEL)) begin
            armed_ff <= 1'b1;
        end
    end
    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            n_shift_ff <= 5'h00;
        end else if (SHIFT_CLK) begin
            n_shift_ff <= n_shift_ff + 5'h01;
        end else if (HALF_SEL) begin
            n_shift_ff <= 5'h00;
        end
    end
    default clocking @(posedge CLOCK); endclocking
    default disable iff (SYS_RST);
    sequence win_s;
        !DECODE_WINDOW_PULSE_N ##1 !DECODE_WINDOW_PULSE_N ##1 DECODE_WINDOW_PULSE_N;
    endsequence
    win_delay_a: assert property ($fell(HALF_SEL) |-> ##[3:5] $fell(DECODE_WINDOW_PULSE_N))
        else $error("decode window late or missing");
    win_width_a: assert property ($fell(DECODE_WINDOW_PULSE_N) |-> win_s)
        else $error("decode window width wrong");
    cmd_window_a: assert property (DEC_CMD != '0 |-> !$past(DECODE_WINDOW_PULSE_N))
        else $error("command outside decode window");
    cmd_noop_a: assert property (!DEC_CMD[0] && !DEC_CMD[8] && $onehot0(DEC_CMD[7:0])
        && $onehot0(DEC_CMD[15:8])) else $error("command group not one-hot");
    strobe_end_a: assert property ($fell(COMMAND_LATCH_STROBE) |-> $fell(HALF_SEL))
        else $error("strobe end without half-select fall");
    strobe_noshift_a: assert property (COMMAND_LATCH_STROBE |-> !SHIFT_CLK)
        else $error("shift pulse during strobe");
    shift_low_a: assert property (SHIFT_CLK |-> !$past(HALF_SEL))
        else $error("shift pulse outside second half");
    adv_follow_a: assert property ($rose(HALF_SEL) |-> ##[1:3] $fell(SEQ_ADV_CLK_N))
        else $error("advance clock missing");
    codes_hold_a: assert property ($fell(HALF_SEL) |=> $stable(FIRST_CODES) [*6])
        else $error("first codes not held");
    addr_msb_a: assert property (STORE_ADDR[mpt_pkg::STATE_W] == HALF_SEL)
        else $error("store address msb mismatch");
    pulse_cnt_a: assert property ($rose(HALF_SEL) && armed_ff |->
        (n_shift_ff + SHIFT_CLK) inside {5'h01, 5'h0f, 5'h10})
        else $error("shift pulse count illegal");
    carry_end_a: assert property ($rose(COUNTER_CARRY) |-> ##[0:1] HALF_SEL)
        else $error("carry did not end shifting");
endmodule : mpt_chk
bind mpt_timing mpt_chk #(.CODE_W(CODE_W), .N_FIELDS(N_FIELDS)) u_chk (.CLOCK(CLOCK),
    .SYS_RST(SYS_RST), .HALF_SEL(HALF_SEL), .SEQ_ADV_CLK_N(SEQ_ADV_CLK_N),
    .COMMAND_LATCH_STROBE(COMMAND_LATCH_STROBE), .DECODE_WINDOW_PULSE_N(DECODE_WINDOW_PULSE_N),
    .SHIFT_CLK(SHIFT_CLK), .COUNTER_CARRY(COUNTER_CARRY), .STORE_ADDR(STORE_ADDR),
    .FIRST_CODES(FIRST_CODES), .DEC_CMD(DEC_CMD));

// File: mpt_store_model.sv
`timescale 1ns/10ps
module mpt_store_model (
    input wire logic [mpt_pkg::STATE_W:0] store_addr,
    input wire logic single_n,
    input wire logic fifteen,
    input wire logic [2:0] fld_a,
    input wire logic [2:0] fld_b,
    output logic [mpt_pkg::CODE_W-1:0] mcode,
    output logic [mpt_pkg::STATE_W-1:0] next_state
);
    // Upper half holds address-tagged first words, so a stale latch shows
    always_comb begin
        if (store_addr[mpt_pkg::STATE_W]) begin
            mcode = {~store_addr, store_addr};
            next_state = store_addr[6:0] + 7'h01;
        end else begin
            mcode = {8'h5a, fifteen, single_n, fld_b, fld_a};
            next_state = ~store_addr[6:0];
        end
    end
endmodule : mpt_store_model

// File: tb_top.sv
`timescale 1ns/10ps
module tb_top;
    logic clock, sys_rst, psel, penable, pwrite, scaler_rd, pready, pslverr, err;
    logic half_sel, adv_n, strobe, win_n, shift_clk, carry, single_n, fifteen, mosc, pis;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] mcode, first_codes, dec_cmd, cmd, fc, f1;
    logic [7:0] store_addr, adr;
    logic [6:0] nsl;
    logic [2:0] fa, fb;
    int n_fail, n_compared, np, t, wd;
    int gaps[$];
    mpt_timing u_dut (.CLOCK(clock), .SYS_RST(sys_rst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .MCODE(mcode), .NEXT_STATE_LINES(nsl), .SCALER_RD(scaler_rd),
        .STORE_ADDR(store_addr), .HALF_SEL(half_sel), .SEQ_ADV_CLK_N(adv_n),
        .COMMAND_LATCH_STROBE(strobe), .DECODE_WINDOW_PULSE_N(win_n), .SHIFT_CLK(shift_clk),
        .PLUGIN_SIDE_CLOCK(pis), .MASTER_OSC_CLOCK(mosc), .COUNTER_CARRY(carry),
        .FIRST_CODES(first_codes), .DEC_CMD(dec_cmd));
    mpt_store_model u_store (.store_addr(store_addr), .single_n(single_n), .fifteen(fifteen),
        .fld_a(fa), .fld_b(fb), .mcode(mcode), .next_state(nsl));
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wdat);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wdat;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) begin
            @(posedge clock);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic do_reset;
        sys_rst <= 1'b1;
        repeat (6) @(posedge clock);
        chk("half_sel", 1'b0, half_sel);
        chk("carry", 1'b1, carry);
        chk("dec_cmd", 16'h0000, dec_cmd);
        sys_rst <= 1'b0;
    endtask : do_reset
    // Divider outputs run free, so their toggle counts fix the tick rate
    task automatic osc_rate;
        logic pm, pp;
        int nm, npi;
        nm = 0;
        npi = 0;
        @(negedge clock);
        pm = mosc;
        pp = pis;
        repeat (100) begin
            @(negedge clock);
            if (mosc !== pm) nm++;
            if (pis !== pp) npi++;
            pm = mosc;
            pp = pis;
        end
        chk("osc_toggles", 100 * mpt_pkg::MOSC_HZ / mpt_pkg::CLK_HZ, nm);
        chk("plugin_toggles", 50 * mpt_pkg::MOSC_HZ / mpt_pkg::CLK_HZ, npi);
    endtask : osc_rate
    // One process cycle: latch first word, then count shifts until half-select rises
    task automatic meas;
        @(negedge clock);
        while (half_sel === 1'b1 && wd < 400) begin
            f1 = mcode;
            @(negedge clock);
            wd++;
        end
        fc = first_codes;
        adr = store_addr;
        np = 0;
        t = 0;
        cmd = 16'h0000;
        gaps.delete();
        forever begin
            cmd = cmd | dec_cmd;
            t++;
            if (shift_clk === 1'b1) begin
                np++;
                gaps.push_back(t);
                t = 0;
            end
            if (half_sel === 1'b1 || wd > 600) break;
            @(negedge clock);
            wd++;
        end
    endtask : meas
    task automatic run_mode(input logic sn, input logic ff, input logic [2:0] a,
                            input logic [2:0] b, input int exp_np, input logic sc);
        logic [15:0] exp_cmd;
        exp_cmd = 16'h0000;
        if (a != 3'h0) exp_cmd[a] = 1'b1;
        if (b != 3'h0) exp_cmd[8 + b] = 1'b1;
        wd = 0;
        while (half_sel !== 1'b1 && wd < 300) begin
            @(negedge clock);
            wd++;
        end
        @(posedge clock);
        single_n <= sn;
        fifteen <= ff;
        fa <= a;
        fb <= b;
        scaler_rd <= sc;
        meas();
        chk("cycle_bound", 1'b1, wd < 600);
        chk("shift_pulses", exp_np, np);
        chk("commands", exp_cmd, cmd);
        chk("first_codes", f1, fc);
        chk("next_addr", 7'(f1[6:0] + 7'h01), adr[6:0]);
    endtask : run_mode
    task automatic conclude;
        $display("Compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : conclude
    initial begin
        #3_000_000;
        n_fail++;
        conclude();
    end
    initial begin
        {psel, penable, pwrite, scaler_rd, fifteen, fa, fb} = '0;
        sys_rst = 1'b1;
        {paddr, pwdata} = '0;
        single_n = 1'b1;
        do_reset();
        osc_rate();
        apb(1'b0, mpt_pkg::ADDR_CTRL, 32'h0000_0000);
        chk("ctrl_reset", mpt_pkg::CTRL_RESET, rd);
        apb(1'b0, 12'h0fc, 32'h0000_0000);
        chk("unmapped_err", 1'b1, err);
        chk("unmapped_rd", 32'h0000_0000, rd);
        apb(1'b1, mpt_pkg::ADDR_CYCLES, 32'hffff_ffff);
        apb(1'b0, mpt_pkg::ADDR_CYCLES, 32'h0000_0000);
        chk("cycles_ro", 32'h0000_0000, rd);
        apb(1'b1, mpt_pkg::ADDR_CTRL, 32'h0000_0001);
        apb(1'b0, mpt_pkg::ADDR_CTRL, 32'h0000_0000);
        chk("ctrl_run", 32'h0000_0001, rd);
        for (int i = 0; i < 8; i++) begin
            run_mode(i % 3 != 0, i % 3 == 1, i[2:0], 3'(7 - i),
                (i % 3 == 0) ? 1 : ((i % 3 == 1) ? 15 : 16), 1'b0);
            if (i % 3 == 2) chk("normal_gap", 5, gaps[2]);
        end
        run_mode(1'b1, 1'b0, 3'h2, 3'h5, 16, 1'b1);
        chk("halved_gap", 10, gaps[2]);
        chk("last_gap", 5, gaps[15]);
        chk("thirteenth_gap", 10, gaps[12]);
        chk("after_halve_gap", 5, gaps[13]);
        scaler_rd <= 1'b0;
        apb(1'b0, mpt_pkg::ADDR_CYCLES, 32'h0000_0000);
        chk("cycles_run", 1'b1, rd != 32'h0000_0000);
        apb(1'b1, mpt_pkg::ADDR_CTRL, 32'h0000_0000);
        repeat (400) @(posedge clock);
        apb(1'b0, mpt_pkg::ADDR_STATUS, 32'h0000_0000);
        chk("stop_state", 32'(mpt_pkg::ST_IDLE), {29'h0000_0000, rd[2:0]});
        chk("stop_levels", 32'h0000_0005, {28'h000_0000, rd[11:8]});
        do_reset();
        conclude();
    end
endmodule : tb_top
